// >>> logic/cmc_map.svh
// Purpose: Offsets, field positions, reset values and counts of the macrocell array
// Assumes: Included by its bare name from the top design module only
// Notes:   Byte addresses on a 32-bit APB bus, one aligned word per register
`ifndef CMC_MAP_SVH
`define CMC_MAP_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define CELL_COUNT      8
`define PT_PER_CELL     8
`define PT_COUNT        64
`define DED_INPUTS      8
`define ARRAY_INPUTS    16
`define ARRAY_COLUMNS   32
`define SYNC_WIDTH      18

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_CTRL       12'h000
`define ADDR_CELLCFG    12'h004
`define ADDR_STATUS     12'h008
`define ADDR_FUSE_BASE  12'h100
`define ADDR_FUSE_LAST  12'h1fc

// ----------------------------------------
// Control fields and reset value
// ----------------------------------------
`define CTRL_MODE_LSB   0
`define CTRL_MODE_MSB   1
`define CTRL_SLEEP_EN   2
`define CTRL_RUN        3
`define CTRL_RESET      32'h0000_0000
`define CELLCFG_RESET   24'h00_0000
`define CELLCFG_STRIDE  3

// ----------------------------------------
// Status fields
// ----------------------------------------
`define STAT_OUT_LSB    0
`define STAT_OE_LSB     8
`define STAT_Q_LSB      16
`define STAT_ASLEEP     24

// ----------------------------------------
// Pin positions
// ----------------------------------------
`define SLEEP_IDX       2

`endif

// >>> logic/cmc_pkg.sv
// Purpose: Types shared by the macrocell array modules
// Assumes: cmc_map.svh holds the numbers
// Notes:   Mode codes follow a Gray walk registered, complex, simple
package cmc_pkg;

    typedef enum logic [1:0] {
        DEV_REGISTERED = 2'b00,
        DEV_COMPLEX    = 2'b01,
        DEV_SIMPLE     = 2'b11
    } dev_mode_t;

    typedef enum logic [1:0] {
        CELL_REGISTERED = 2'b00,
        CELL_COMB       = 2'b01,
        CELL_INPUT      = 2'b11
    } cell_mode_t;

endpackage : cmc_pkg

// >>> logic/pin_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes:   The first stage feeds only the second stage
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 18
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_ff
);
    logic [WIDTH-1:0] meta_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end
endmodule : pin_sync

// >>> logic/macrocell_slice.sv
// Purpose: One output macrocell: sum term, register, polarity, output enable
// Assumes: Product terms and pin levels arrive already synchronised
// Notes:   All outputs are registers; frozen holds every one of them
`timescale 1ns/100ps
module macrocell_slice
    import cmc_pkg::*;
#(
    parameter bit OUTER  = 1'b0,
    parameter bit CENTER = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  pt,
    input  cmc_pkg::dev_mode_t  dev_mode,
    input  cmc_pkg::cell_mode_t cell_mode,
    input  wire logic        polarity,
    input  wire logic        oe_n_s,
    input  wire logic        clk_rise,
    input  wire logic        frozen,
    input  wire logic        active,
    output logic             pin_o_ff,
    output logic             pin_oe_ff,
    output logic             q_ff
);
    import cmc_pkg::*;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire use_reg   = (dev_mode == DEV_REGISTERED) && (cell_mode == CELL_REGISTERED);
    wire force_out = ((dev_mode == DEV_SIMPLE) && CENTER)
                   || ((dev_mode == DEV_COMPLEX) && OUTER);
    wire is_input  = (cell_mode == CELL_INPUT) && !force_out;
    wire pt_oe     = (dev_mode != DEV_SIMPLE);
    wire sum_all   = |pt;
    wire sum_seven = |pt[7:1];
    wire comb_val  = (pt_oe ? sum_seven : sum_all) ^ polarity;

    // Register only steps on a common clock pin edge
    wire nxt_q  = (use_reg && clk_rise) ? sum_all : q_ff;
    // Registered pins show the inverted register, so a cleared register reads high
    wire nxt_o  = use_reg ? ~nxt_q : comb_val;
    wire nxt_oe = (!active || is_input) ? 1'b0 :
                  use_reg  ? ~oe_n_s :
                  pt_oe    ? pt[0]   : 1'b1;

    // ----------------------------------------
    // State
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q_ff      <= 1'b0;
            pin_o_ff  <= 1'b1;
            pin_oe_ff <= 1'b0;
        end else if (!frozen) begin
            q_ff      <= nxt_q;
            pin_o_ff  <= nxt_o;
            pin_oe_ff <= nxt_oe;
        end
    end
endmodule : macrocell_slice

// >>> logic/configurable_macrocell_array.sv
// What this block does
// - Registered mode: registered cells clock on clock pin, enable from active-low OE pin
// - Registered mode: registered cell sum is OR of eight product terms
// - Registered mode: combinatorial cell uses one term for enable, seven for sum
// - A cell configured as input never drives its pin, except outermost cells in complex mode and center cells in simple mode
// - Registered mode: each cell selects registered, combinatorial or input
// - Registered mode: clock and OE pins never reach the array
// - Complex mode: clock and OE pins enter via outermost cells' feedback slots
// - Complex mode: outermost cells are outputs only; inner six feed pins back
// - Complex mode: seven terms form the sum, one term drives enable
// - Simple mode: eight-term sum, no term enable, clock and OE pins are inputs
// - Simple mode: center cells always driven combinatorial outputs, no feedback
// - Simple mode: pin feedback uses the neighbouring cell's slot
// - Simple mode: other cells select input or combinatorial output with feedback
// - With sleep enabled, the sleep pin never feeds the array
// - Reset clears all registers except the pin output registers, which load high so every pin reads high
// - While asleep, outputs and state freeze and inputs are ignored
//
// Purpose: Eight-macrocell programmable array with APB configuration
// Assumes: Pins are asynchronous and pass two flip-flops; the bench resolves io wires
// Notes:   Configuration locks while run is set; pin edges are seen two to three cycles late
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`include "cmc_map.svh"
module configurable_macrocell_array (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        clk_pin,
    input  wire logic        oe_n_pin,
    input  wire logic [7:0]  in_pin,
    input  wire logic [7:0]  io_i,
    output logic      [7:0]  io_o,
    output logic      [7:0]  io_oe
);
    import cmc_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic cell_mode_t cell_mode_of(input logic [23:0] cfg, input int idx);
        logic [1:0] code;
        code = cfg[idx*`CELLCFG_STRIDE +: 2];
        return cell_mode_t'(code);
    endfunction : cell_mode_of

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [1:0]  mode_ff;
    logic        sleep_en_ff;
    logic        run_ff;
    logic [23:0] cellcfg_ff;
    logic [31:0] fuse_ff [`PT_COUNT];
    logic [31:0] rdata_ff;
    logic        ready_ff;
    logic        err_ff;
    logic        asleep_ff;
    logic        clk_prev_ff;
    logic [`ARRAY_INPUTS-1:0] array_in_ff;

    dev_mode_t   dev_mode;
    assign dev_mode = dev_mode_t'(mode_ff);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [`SYNC_WIDTH-1:0] pins_s;

    pin_sync #(
        .WIDTH (`SYNC_WIDTH)
    ) u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in ({clk_pin, oe_n_pin, in_pin, io_i}),
        .sync_ff  (pins_s)
    );

    // Bit order follows the concatenation into the synchroniser
    wire       clk_s       = pins_s[17];
    wire       oe_n_s      = pins_s[16];
    wire [7:0] in_s        = pins_s[15:8];
    wire [7:0] io_s        = pins_s[7:0];
    wire       sleep_pin_s = in_s[`SLEEP_IDX];

    // Sleep acts only when the option is on; the pin then carries no logic
    wire       nxt_asleep  = sleep_en_ff && sleep_pin_s;
    wire       frozen      = asleep_ff;
    wire       clk_rise    = clk_s && !clk_prev_ff;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    // One cycle from setup to answer: zero wait states, reads sample the setup cycle
    wire        setup     = psel && !penable;
    wire        access    = psel && penable && ready_ff;
    wire        hit_ctrl  = (paddr == `ADDR_CTRL);
    wire        hit_cell  = (paddr == `ADDR_CELLCFG);
    wire        hit_stat  = (paddr == `ADDR_STATUS);
    wire        hit_fuse  = (paddr >= `ADDR_FUSE_BASE) && (paddr <= `ADDR_FUSE_LAST)
                            && (paddr[1:0] == 2'b00);
    wire [5:0]  fuse_idx  = paddr[7:2];
    wire        mapped    = hit_ctrl || hit_cell || hit_stat || hit_fuse;
    // Locked configuration: only the run bit may change while running
    wire        locked_wr = pwrite && run_ff && (hit_cell || hit_fuse);
    wire        bad_wr    = pwrite && hit_stat;
    wire        nxt_err   = !mapped || locked_wr || bad_wr;
    wire        wr_ok     = access && pwrite && !err_ff;

    wire [31:0] ctrl_word = {28'h000_0000, run_ff, sleep_en_ff, mode_ff};
    wire [31:0] stat_word;
    logic [7:0] out_bits;
    logic [7:0] oe_bits;
    logic [7:0] q_bits;
    assign stat_word = {7'h00, asleep_ff, q_bits, oe_bits, out_bits};

    wire [31:0] nxt_rdata = (!psel || pwrite) ? 32'h0000_0000 :
                            hit_ctrl ? ctrl_word :
                            hit_cell ? {8'h00, cellcfg_ff} :
                            hit_stat ? stat_word :
                            hit_fuse ? fuse_ff[fuse_idx] : 32'h0000_0000;

    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ready_ff <= 1'b0;
            err_ff   <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ready_ff <= setup;
            err_ff   <= setup && nxt_err;
            rdata_ff <= setup ? nxt_rdata : 32'h0000_0000;
        end
    end

    assign prdata  = rdata_ff;
    assign pready  = ready_ff;
    assign pslverr = err_ff;

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    wire [1:0] nxt_mode = (wr_ok && hit_ctrl && !run_ff) ?
                          pwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB] : mode_ff;
    wire nxt_sleep_en   = (wr_ok && hit_ctrl && !run_ff) ? pwdata[`CTRL_SLEEP_EN] : sleep_en_ff;
    wire nxt_run        = (wr_ok && hit_ctrl) ? pwdata[`CTRL_RUN] : run_ff;
    wire [23:0] nxt_cellcfg = (wr_ok && hit_cell) ? pwdata[23:0] : cellcfg_ff;
    // Reset image of the control word, split into its fields below
    wire [31:0] ctrl_rst    = `CTRL_RESET;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_ff     <= ctrl_rst[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
            sleep_en_ff <= ctrl_rst[`CTRL_SLEEP_EN];
            run_ff      <= ctrl_rst[`CTRL_RUN];
            cellcfg_ff  <= `CELLCFG_RESET;
        end else begin
            mode_ff     <= nxt_mode;
            sleep_en_ff <= nxt_sleep_en;
            run_ff      <= nxt_run;
            cellcfg_ff  <= nxt_cellcfg;
        end
    end

    // Fuse words: one per product term, two columns per array input
    genvar gf;
    generate
        for (gf = 0; gf < `PT_COUNT; gf++) begin : g_fuse
            wire fuse_we = wr_ok && hit_fuse && (fuse_idx == 6'(gf));
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    fuse_ff[gf] <= 32'h0000_0000;
                end else if (fuse_we) begin
                    fuse_ff[gf] <= pwdata;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Sleep and clock pin edge
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            asleep_ff   <= 1'b0;
            clk_prev_ff <= 1'b0;
        end else begin
            asleep_ff   <= nxt_asleep;
            // Edge history frozen too, so a clock pin rise during sleep counts as an edge on waking
            clk_prev_ff <= frozen ? clk_prev_ff : clk_s;
        end
    end

    // ----------------------------------------
    // Array inputs and feedback routing
    // ----------------------------------------
    logic [`DED_INPUTS-1:0] nxt_ded;
    logic [7:0]             nxt_fb;

    always_comb begin
        nxt_ded = in_s;
        if (sleep_en_ff) begin
            nxt_ded[`SLEEP_IDX] = 1'b0;
        end
    end

    genvar gb;
    generate
        for (gb = 0; gb < `CELL_COUNT; gb++) begin : g_fb
            cell_mode_t cm;
            assign cm = cell_mode_of(cellcfg_ff, gb);
            // Registered cells feed back their register, others their pin
            wire reg_fb = (cm == CELL_REGISTERED) ? q_bits[gb] : io_s[gb];
            wire cpx_fb = (gb == 0) ? oe_n_s :
                          (gb == 7) ? clk_s  : io_s[gb];
            // Outer pins shift one slot inward; center pins lose theirs
            wire smp_fb = (gb == 0) ? oe_n_s :
                          (gb == 7) ? clk_s  :
                          (gb < 4)  ? io_s[(gb + 7) % 8] : io_s[(gb + 1) % 8];
            // Code 10 is not a mode of its own; it routes as registered
            always_comb begin
                unique case (dev_mode)
                    DEV_REGISTERED: nxt_fb[gb] = reg_fb;
                    DEV_COMPLEX:    nxt_fb[gb] = cpx_fb;
                    DEV_SIMPLE:     nxt_fb[gb] = smp_fb;
                    default:        nxt_fb[gb] = reg_fb;
                endcase
            end
        end
    endgenerate

    // Inputs are sampled only while awake, so the array sees nothing new asleep
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            array_in_ff <= '0;
        end else if (!frozen) begin
            array_in_ff <= {nxt_fb, nxt_ded};
        end
    end

    // ----------------------------------------
    // AND-array
    // ----------------------------------------
    logic [`ARRAY_COLUMNS-1:0] lits;
    logic [`PT_COUNT-1:0]      pt;

    genvar gl;
    generate
        for (gl = 0; gl < `ARRAY_INPUTS; gl++) begin : g_lit
            assign lits[2*gl]   = array_in_ff[gl];
            assign lits[2*gl+1] = ~array_in_ff[gl];
        end
        // A term with no connected column is off, as an unused term should be
        for (gl = 0; gl < `PT_COUNT; gl++) begin : g_pt
            assign pt[gl] = (|fuse_ff[gl]) && (&(lits | ~fuse_ff[gl]));
        end
    endgenerate

    // ----------------------------------------
    // Macrocells
    // ----------------------------------------
    // Cell outputs are flip-flops already, so the pins need no extra stage
    genvar gc;
    generate
        for (gc = 0; gc < `CELL_COUNT; gc++) begin : g_cell
            macrocell_slice #(
                .OUTER  ((gc == 0) || (gc == 7)),
                .CENTER ((gc == 3) || (gc == 4))
            ) u_cell (
                .clk       (clk),
                .sys_rst   (sys_rst),
                .pt        (pt[gc*`PT_PER_CELL +: `PT_PER_CELL]),
                .dev_mode  (dev_mode),
                .cell_mode (cell_mode_of(cellcfg_ff, gc)),
                .polarity  (cellcfg_ff[gc*`CELLCFG_STRIDE + 2]),
                .oe_n_s    (oe_n_s),
                .clk_rise  (clk_rise),
                .frozen    (frozen),
                .active    (run_ff),
                .pin_o_ff  (out_bits[gc]),
                .pin_oe_ff (oe_bits[gc]),
                .q_ff      (q_bits[gc])
            );
        end
    endgenerate

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign io_o  = out_bits;
    assign io_oe = oe_bits;

endmodule : configurable_macrocell_array

// >>> dv/cmc_chk.sv
// Purpose: Port-level assertions for the macrocell array
// Assumes: Zero-wait APB slave, synchronous active-high reset
// Notes:   Bound to every instance of the top module
`timescale 1ns/100ps
module cmc_chk (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  io_o,
    input wire logic [7:0]  io_oe
);
    // ----------------------------------------
    // Bus and reset checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence setup_s;
        psel && !penable;
    endsequence
    apb_wait_a: assert property (setup_s |=> pready) else $error("no zero-wait answer");
    ready_place_a: assert property (pready |-> psel && penable) else $error("ready outside access");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held two cycles");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data not cleared");
    err_qual_a: assert property (pslverr |-> pready) else $error("error without ready");
    stat_write_a: assert property (setup_s ##0 pwrite && paddr == 12'h008 |=> pslverr)
        else $error("status write not refused");
    unmapped_a: assert property (setup_s ##0 paddr == 12'h00c |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    // Reset check must run while reset is high, so it overrides the default disable
    reset_out_a: assert property (disable iff (1'b0) sys_rst |=> io_oe == 8'h00 && io_o == 8'hff)
        else $error("outputs wrong after reset");
endmodule : cmc_chk
bind configurable_macrocell_array cmc_chk u_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io_o(io_o), .io_oe(io_oe));

// >>> dv/board_model.sv
// Purpose: Board side of the macrocell pins
// Assumes: No board driver on the macrocell pins
// Notes:   A released pin keeps its last level, as a pin keeper would
`timescale 1ns/100ps
module board_model (
    input  wire logic       clk,
    input  wire logic [7:0] io_o,
    input  wire logic [7:0] io_oe,
    output logic      [7:0] io_i
);
    logic [7:0] keep_ff = 8'h00;
    always_ff @(posedge clk) begin
        keep_ff <= io_i;
    end
    assign io_i = (io_oe & io_o) | (~io_oe & keep_ff);
endmodule : board_model

// >>> dv/tb.sv
// Purpose: Self-checking bench for the macrocell array
// Assumes: Pin changes show at io_o/io_oe within ten clocks
// Notes:   Pins are driven directly; the board model resolves io wires
`timescale 1ns/100ps
module tb;
    import cmc_pkg::*;
    logic        clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic        pready, pslverr, e, clk_pin = 1'b0, oe_n_pin = 1'b1;
    logic [7:0]  in_pin = 8'h00, io_i, io_o, io_oe, so, soe;
    int          n_mismatch = 0, tests_run = 0;
    always #2.5 clk = ~clk;
    configurable_macrocell_array dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .in_pin(in_pin), .io_i(io_i),
        .io_o(io_o), .io_oe(io_oe));
    board_model u_board (.clk(clk), .io_o(io_o), .io_oe(io_oe), .io_i(io_i));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // No cycle count assumed: only the watchdog may end a hung transfer
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        d = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] wd, input logic xe);
        apb(1'b1, a, wd);
        chk(e, xe);
    endtask : wr
    task settle;
        repeat (10) @(posedge clk);
    endtask : settle
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        chk(io_o, 8'hff);
        chk(io_oe, 8'h00);
        apb(1'b0, 12'h008, 32'h0);
        chk(d, 32'h0000_00ff);
        $display("test reset done");
    endtask : t_reset
    task t_registered;
        wr(12'h004, 32'h006d_b6c8, 1'b0);
        wr(12'h100, 32'h0000_0004, 1'b0);
        wr(12'h120, 32'h0000_0002, 1'b0);
        wr(12'h124, 32'h0000_0001, 1'b0);
        wr(12'h140, 32'h0000_0004, 1'b0);
        in_pin <= 8'h02; oe_n_pin <= 1'b0;
        wr(12'h000, 32'h0000_0008, 1'b0);
        settle;
        chk(io_oe[0], 1'b1);
        chk(io_o[0], 1'b1);
        chk(io_oe[1], 1'b1);
        chk(io_o[1], 1'b0);
        chk(io_oe[2], 1'b0);
        clk_pin <= 1'b1;
        settle;
        chk(io_o[0], 1'b0);
        clk_pin <= 1'b0; oe_n_pin <= 1'b1;
        settle;
        chk(io_oe[0], 1'b0);
        wr(12'h004, 32'h0, 1'b1);
        wr(12'h008, 32'h0, 1'b1);
        apb(1'b0, 12'h00c, 32'h0);
        chk(e, 1'b1);
        chk(d, 32'h0);
        $display("test registered done");
    endtask : t_registered
    task t_complex;
        wr(12'h000, 32'h0, 1'b0);
        wr(12'h000, 32'h1, 1'b0);
        wr(12'h124, 32'h0001_0000, 1'b0);
        wr(12'h1e0, 32'h0000_0004, 1'b0);
        wr(12'h000, 32'h9, 1'b0);
        settle;
        chk(io_oe[7], 1'b1);
        chk(io_oe[2], 1'b0);
        chk(io_o[1], 1'b1);
        oe_n_pin <= 1'b0;
        settle;
        chk(io_o[1], 1'b0);
        chk(io_oe[1], 1'b1);
        $display("test complex done");
    endtask : t_complex
    task t_simple;
        wr(12'h000, 32'h0, 1'b0);
        wr(12'h000, 32'h3, 1'b0);
        wr(12'h120, 32'h0, 1'b0);
        wr(12'h124, 32'h0004_0000, 1'b0);
        wr(12'h000, 32'hb, 1'b0);
        settle;
        chk(io_oe[4:3], 2'b11);
        chk(io_oe[0], 1'b1);
        chk(io_o[0], 1'b1);
        chk(io_o[1], 1'b1);
        chk(io_oe[2], 1'b0);
        in_pin <= 8'h00;
        settle;
        chk(io_o[1:0], 2'b00);
        $display("test simple done");
    endtask : t_simple
    task t_sleep;
        wr(12'h000, 32'h0, 1'b0);
        wr(12'h000, 32'h4, 1'b0);
        oe_n_pin <= 1'b1;
        wr(12'h000, 32'hc, 1'b0);
        in_pin <= 8'h06;
        settle;
        apb(1'b0, 12'h008, 32'h0);
        chk(d[24], 1'b1);
        so = io_o; soe = io_oe;
        oe_n_pin <= 1'b0; clk_pin <= 1'b1; in_pin <= 8'h04;
        settle;
        chk({io_o, io_oe}, {so, soe});
        clk_pin <= 1'b0;
        $display("test sleep done");
    endtask : t_sleep
    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task results;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_registered;
        t_complex;
        t_simple;
        t_sleep;
        results;
    end
    // Whole run is well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        results;
    end
endmodule : tb
